//--- logic/lvac_pkg.sv
// Constants, field layout and types of the low-voltage and converter control block
package lvac_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Byte offsets of the register file
  localparam logic [ADDR_W-1:0] OFF_CONV_CTRL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LOW_BAT    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_RESULT     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h1C;

  // Converter control fields
  localparam int unsigned CC_ANALOG_LSB = 4;
  localparam int unsigned CC_ANALOG_W   = 4;
  localparam int unsigned CC_CHAN_LSB   = 2;
  localparam int unsigned CC_CHAN_W     = 2;
  localparam int unsigned CC_POWER_BIT  = 1;
  localparam int unsigned CC_HALF_BIT   = 0;

  // Low-battery control fields
  localparam int unsigned LOW_BAT_ENABLE_BIT = 0;
  localparam int unsigned LOW_BAT_FLAG_BIT   = 1;
  localparam int unsigned LOW_BAT_PAD_BIT    = 2;
  localparam int unsigned LOW_BAT_RSVD_LSB   = 3;
  localparam int unsigned LOW_BAT_RSVD_W     = 5;
  localparam logic [LOW_BAT_RSVD_W-1:0] LOW_BAT_RSVD_VALUE = 5'h1F;

  // Reset values
  localparam logic [DATA_W-1:0] CONV_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RESULT_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE       = 8'h00;

  // Interrupt status bits
  localparam int unsigned IRQ_TRIP    = 0;
  localparam int unsigned IRQ_CONV    = 1;
  localparam int unsigned IRQ_SETTLED = 2;
  localparam int unsigned IRQ_W       = 3;

  // Detector settling time
  localparam int unsigned CLK_FREQ_MHZ   = 200;
  localparam int unsigned SETTLE_TIME_NS = 20000;
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_CNT_W   = 12;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } lvac_bus_req_s;

  typedef struct packed {
    logic [CC_ANALOG_W-1:0] analog_sel;
    logic [CC_CHAN_W-1:0]   channel;
    logic                   power;
    logic                   half_clk;
  } lvac_conv_ctrl_s;

  typedef enum logic [1:0] {
    LVAC_DET_OFF,
    LVAC_DET_SETTLE,
    LVAC_DET_ARMED
  } lvac_det_e;

endpackage

//--- logic/lvac_sync.sv
// Multi-bit level synchroniser for asynchronous analog comparator outputs
module lvac_sync #(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned STAGES = lvac_pkg::SYNC_STAGES
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  generate
    if (WIDTH < 1 || STAGES < 2) begin : g_bad
      $error("lvac_sync needs WIDTH of at least 1 and STAGES of at least 2");
    end
  endgenerate

  // Only the last stage is visible; earlier stages may be metastable
  logic [WIDTH-1:0] stage_q [STAGES];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule

//--- logic/lvac_top.sv
// Low-battery detector control and analog converter control register block
//
// The plain strobed port was chosen for this implementation.

module lvac_top #(
  parameter int unsigned SETTLE_CYCLES = lvac_pkg::SETTLE_CYCLES,
  parameter int unsigned RESULT_W      = lvac_pkg::DATA_W
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire lvac_pkg::lvac_bus_req_s       bus_req,
  output logic [lvac_pkg::DATA_W-1:0]        rd_data_q,
  input  wire logic                          lvd_trip_async,
  input  wire logic                          pad_unregulated_async,
  input  wire logic                          timer_one_irq,
  input  wire logic                          conv_valid,
  input  wire logic [RESULT_W-1:0]           conv_data,
  output lvac_pkg::lvac_conv_ctrl_s          conv_ctrl_q,
  output logic                               conv_tick_q,
  output logic                               irq_five_q,
  output logic                               irq_q
);

  generate
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << lvac_pkg::SETTLE_CNT_W)) begin : g_bad_settle
      $error("lvac_top SETTLE_CYCLES must fit the settle counter and be at least 1");
    end
    if (RESULT_W != lvac_pkg::DATA_W) begin : g_bad_width
      $error("lvac_top RESULT_W must equal the register data width");
    end
  endgenerate

  localparam logic [lvac_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
    lvac_pkg::SETTLE_CNT_W'(SETTLE_CYCLES - 1);

  // Comparator inputs arrive from analog, so both pass a two-stage synchroniser
  logic [1:0] cmp_sync;
  logic       trip_level;
  logic       pad_unregulated;

  lvac_sync #(
    .WIDTH  (2),
    .STAGES (lvac_pkg::SYNC_STAGES)
  ) i_lvac_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({pad_unregulated_async, lvd_trip_async}),
    .sync_out (cmp_sync)
  );

  assign trip_level      = cmp_sync[0];
  assign pad_unregulated = cmp_sync[1];

  // Address decode
  logic hit_conv_ctrl;
  logic hit_low_bat;
  logic hit_result;
  logic hit_irq_status;
  logic hit_irq_clear;
  logic hit_irq_enable;
  logic wr_conv_ctrl;
  logic wr_low_bat;
  logic wr_irq_clear;
  logic wr_irq_enable;

  assign hit_conv_ctrl  = (bus_req.addr == lvac_pkg::OFF_CONV_CTRL);
  assign hit_low_bat    = (bus_req.addr == lvac_pkg::OFF_LOW_BAT);
  assign hit_result     = (bus_req.addr == lvac_pkg::OFF_RESULT);
  assign hit_irq_status = (bus_req.addr == lvac_pkg::OFF_IRQ_STATUS);
  assign hit_irq_clear  = (bus_req.addr == lvac_pkg::OFF_IRQ_CLEAR);
  assign hit_irq_enable = (bus_req.addr == lvac_pkg::OFF_IRQ_ENABLE);

  assign wr_conv_ctrl  = bus_req.wr && hit_conv_ctrl;
  assign wr_low_bat    = bus_req.wr && hit_low_bat;
  assign wr_irq_clear  = bus_req.wr && hit_irq_clear;
  assign wr_irq_enable = bus_req.wr && hit_irq_enable;

  // Converter control register
  lvac_pkg::lvac_conv_ctrl_s conv_ctrl_d;

  assign conv_ctrl_d.analog_sel =
    bus_req.wdata[lvac_pkg::CC_ANALOG_LSB +: lvac_pkg::CC_ANALOG_W];
  assign conv_ctrl_d.channel    =
    bus_req.wdata[lvac_pkg::CC_CHAN_LSB +: lvac_pkg::CC_CHAN_W];
  assign conv_ctrl_d.power      = bus_req.wdata[lvac_pkg::CC_POWER_BIT];
  assign conv_ctrl_d.half_clk   = bus_req.wdata[lvac_pkg::CC_HALF_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_ctrl_q <= lvac_pkg::CONV_CTRL_RESET;
    end else if (wr_conv_ctrl) begin
      conv_ctrl_q <= conv_ctrl_d;
    end
  end

  // Converter clock rate: a tick every cycle, or every second cycle in half mode
  logic phase_q;
  logic conv_tick_d;

  assign conv_tick_d = conv_ctrl_q.power && (!conv_ctrl_q.half_clk || phase_q);

  // Phase runs only at half rate, so a change to half rate restarts from a tick-free cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= conv_ctrl_q.power && conv_ctrl_q.half_clk && !phase_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_tick_q <= 1'b0;
    end else begin
      conv_tick_q <= conv_tick_d;
    end
  end

  // Conversion result, read-only to software
  logic [RESULT_W-1:0] result_q;
  logic                conv_done;

  // A result offered while powered down is stale and is dropped
  assign conv_done = conv_valid && conv_ctrl_q.power;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_q <= lvac_pkg::RESULT_RESET;
    end else if (conv_done) begin
      result_q <= conv_data;
    end
  end

  // Low-battery detection
  logic                            detect_en_q;
  logic                            trip_flag_q;
  logic [lvac_pkg::SETTLE_CNT_W-1:0] settle_cnt_q;
  lvac_pkg::lvac_det_e             det_q;
  lvac_pkg::lvac_det_e             det_d;
  logic                            settle_done;
  logic                            trip_set;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      detect_en_q <= 1'b0;
    end else if (wr_low_bat) begin
      detect_en_q <= bus_req.wdata[lvac_pkg::LOW_BAT_ENABLE_BIT];
    end
  end

  // The comparator needs time to settle after enable; its output is ignored until then
  assign settle_done = (det_q == lvac_pkg::LVAC_DET_SETTLE) && (settle_cnt_q == SETTLE_LAST);

  always_comb begin
    det_d = det_q;
    unique case (det_q)
      lvac_pkg::LVAC_DET_OFF: begin
        if (detect_en_q) begin
          det_d = lvac_pkg::LVAC_DET_SETTLE;
        end
      end
      lvac_pkg::LVAC_DET_SETTLE: begin
        if (!detect_en_q) begin
          det_d = lvac_pkg::LVAC_DET_OFF;
        end else if (settle_done) begin
          det_d = lvac_pkg::LVAC_DET_ARMED;
        end
      end
      lvac_pkg::LVAC_DET_ARMED: begin
        if (!detect_en_q) begin
          det_d = lvac_pkg::LVAC_DET_OFF;
        end
      end
      default: begin
        det_d = lvac_pkg::LVAC_DET_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      det_q        <= lvac_pkg::LVAC_DET_OFF;
      settle_cnt_q <= '0;
    end else begin
      det_q <= det_d;
      if (det_q == lvac_pkg::LVAC_DET_SETTLE) begin
        settle_cnt_q <= settle_cnt_q + 1'b1;
      end else begin
        settle_cnt_q <= '0;
      end
    end
  end

  // Flag is sticky while enabled; disabling detection discards it
  assign trip_set = (det_q == lvac_pkg::LVAC_DET_ARMED) && detect_en_q && trip_level;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trip_flag_q <= 1'b0;
    end else if (!detect_en_q) begin
      trip_flag_q <= 1'b0;
    end else if (trip_set) begin
      trip_flag_q <= 1'b1;
    end
  end

  // Interrupt five: trip owns the line while detection is on
  logic irq_five_d;

  assign irq_five_d = detect_en_q ? trip_flag_q : timer_one_irq;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_five_q <= 1'b0;
    end else begin
      irq_five_q <= irq_five_d;
    end
  end

  // Event status, clear and enable
  logic [lvac_pkg::IRQ_W-1:0] irq_status_q;
  logic [lvac_pkg::IRQ_W-1:0] irq_status_d;
  logic [lvac_pkg::IRQ_W-1:0] irq_enable_q;
  logic [lvac_pkg::IRQ_W-1:0] irq_events;
  logic [lvac_pkg::IRQ_W-1:0] irq_clear;
  logic                       irq_pending;

  assign irq_events[lvac_pkg::IRQ_TRIP]    = trip_set && !trip_flag_q;
  assign irq_events[lvac_pkg::IRQ_CONV]    = conv_done;
  assign irq_events[lvac_pkg::IRQ_SETTLED] = settle_done && detect_en_q;

  assign irq_clear = wr_irq_clear ? bus_req.wdata[lvac_pkg::IRQ_W-1:0] : '0;

  // New events win over a clear in the same cycle, so no event is lost to a racing clear
  assign irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
  assign irq_pending  = |(irq_status_q & irq_enable_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_enable_q <= '0;
    end else if (wr_irq_enable) begin
      irq_enable_q <= bus_req.wdata[lvac_pkg::IRQ_W-1:0];
    end
  end

  // Registered so the pin comes from a flop; it lags the status bit by one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_pending;
    end
  end

  // Read path: data stand in the cycle after the strobe only
  logic [lvac_pkg::DATA_W-1:0] low_bat_view;
  logic [lvac_pkg::DATA_W-1:0] conv_ctrl_view;
  logic [lvac_pkg::DATA_W-1:0] status_view;
  logic [lvac_pkg::DATA_W-1:0] enable_view;
  logic [lvac_pkg::DATA_W-1:0] rd_mux;

  assign low_bat_view = {lvac_pkg::LOW_BAT_RSVD_VALUE, pad_unregulated,
                         trip_flag_q, detect_en_q};
  assign conv_ctrl_view = conv_ctrl_q;
  assign status_view    = {{(lvac_pkg::DATA_W - lvac_pkg::IRQ_W){1'b0}}, irq_status_q};
  assign enable_view    = {{(lvac_pkg::DATA_W - lvac_pkg::IRQ_W){1'b0}}, irq_enable_q};

  assign rd_mux = hit_conv_ctrl  ? conv_ctrl_view :
                  hit_low_bat    ? low_bat_view   :
                  hit_result     ? result_q       :
                  hit_irq_status ? status_view    :
                  hit_irq_enable ? enable_view    :
                  lvac_pkg::READ_IDLE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_q <= lvac_pkg::READ_IDLE;
    end else if (bus_req.rd) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= lvac_pkg::READ_IDLE;
    end
  end

endmodule

//--- tb/lvac_top_asserts.sv
// Concurrent checks on the ports of the low-voltage and converter control block
module lvac_top_asserts (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire lvac_pkg::lvac_bus_req_s     bus_req,
  input wire logic [lvac_pkg::DATA_W-1:0] rd_data_q,
  input wire logic                        timer_one_irq,
  input wire lvac_pkg::lvac_conv_ctrl_s   conv_ctrl_q,
  input wire logic                        conv_tick_q,
  input wire logic                        irq_five_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_q;
  logic en_d;
  logic low_bat_wr;
  assign low_bat_wr = bus_req.wr && (bus_req.addr == lvac_pkg::OFF_LOW_BAT);
  assign en_d = low_bat_wr ? bus_req.wdata[lvac_pkg::LOW_BAT_ENABLE_BIT] : en_q;
  // Shadow of the detection enable, rebuilt from bus writes only
  always_ff @(posedge clk) begin
    en_q <= sys_rst ? 1'b0 : en_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_rd_idle: assert property (!$past(bus_req.rd) |-> rd_data_q == 8'h00)
    else $error("read data not idle");
  chk_ctrl_write: assert property (
    bus_req.wr && bus_req.addr == lvac_pkg::OFF_CONV_CTRL |=> conv_ctrl_q == $past(bus_req.wdata))
    else $error("control write not stored");
  chk_ctrl_read: assert property (
    bus_req.rd && bus_req.addr == lvac_pkg::OFF_CONV_CTRL |=> rd_data_q == $past(conv_ctrl_q))
    else $error("control read mismatch");
  chk_rsvd_ones: assert property (
    bus_req.rd && bus_req.addr == lvac_pkg::OFF_LOW_BAT |=> rd_data_q[7:3] == 5'h1F)
    else $error("reserved bits not ones");
  chk_enable_read: assert property (
    bus_req.rd && bus_req.addr == lvac_pkg::OFF_LOW_BAT |=> rd_data_q[0] == $past(en_q))
    else $error("enable bit read mismatch");
  chk_tick_off: assert property (
    !conv_ctrl_q.power && !$past(conv_ctrl_q.power) |-> !conv_tick_q)
    else $error("tick while powered off");
  chk_tick_full: assert property (
    (conv_ctrl_q.power && !conv_ctrl_q.half_clk) [*3] |-> conv_tick_q)
    else $error("full rate tick missing");
  chk_tick_half: assert property (
    (conv_ctrl_q.power && conv_ctrl_q.half_clk) [*4] |-> conv_tick_q != $past(conv_tick_q))
    else $error("half rate tick not alternating");
  chk_interrupt_request_five_timer: assert property (!en_q |=> irq_five_q == $past(timer_one_irq))
    else $error("timer not routed while disabled");
  chk_interrupt_request_five_flag: assert property (
    bus_req.rd && bus_req.addr == lvac_pkg::OFF_LOW_BAT && en_q |=>
      irq_five_q == rd_data_q[lvac_pkg::LOW_BAT_FLAG_BIT])
    else $error("interrupt five differs from trip flag");
endmodule

bind lvac_top lvac_top_asserts i_lvac_top_asserts (
  .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data_q(rd_data_q),
  .timer_one_irq(timer_one_irq), .conv_ctrl_q(conv_ctrl_q), .conv_tick_q(conv_tick_q),
  .irq_five_q(irq_five_q));

//--- tb/lvac_top_tb.sv
// Self-checking bench for the low-voltage and converter control block
module lvac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk;
  logic                      sys_rst;
  lvac_pkg::lvac_bus_req_s   bus_req;
  logic [7:0]                rd_data_q;
  logic                      lvd_trip_async;
  logic                      pad_unregulated_async;
  logic                      timer_one_irq;
  logic                      conv_valid;
  logic [7:0]                conv_data;
  lvac_pkg::lvac_conv_ctrl_s conv_ctrl_q;
  logic                      conv_tick_q;
  logic                      irq_five_q;
  logic                      irq_q;
  int                        n_mismatch;
  int                        samples_checked;
  logic [7:0]                rv;

  // Short settle count keeps the run brief
  lvac_top #(.SETTLE_CYCLES(8)) i_lvac_top (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data_q(rd_data_q),
    .lvd_trip_async(lvd_trip_async), .pad_unregulated_async(pad_unregulated_async),
    .timer_one_irq(timer_one_irq), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_ctrl_q(conv_ctrl_q), .conv_tick_q(conv_tick_q), .irq_five_q(irq_five_q),
    .irq_q(irq_q));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand in the cycle after the strobe and are taken at the edge closing it
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(posedge clk);
    rv = rd_data_q;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic t_reset;
    check(conv_tick_q, 1'b0);
    rd(8'h08);
    check(rv, 8'h00);
    rd(8'h10);
    check(rv, 8'h00);
    rd(8'h0C);
    check(rv, 8'hF8);
    rd(8'h1C);
    check(rv, 8'h00);
    $display("test reset done");
  endtask

  // Analog-selected pins are taken to be in input mode with their digital buffers off
  task automatic t_ctrl;
    logic [7:0] v [4] = '{8'h96, 8'h69, 8'hF0, 8'h0F};
    logic       tick_seen;
    foreach (v[i]) begin
      wr(8'h08, v[i]);
      rd(8'h08);
      check(rv, v[i]);
      check(conv_ctrl_q, v[i]);
      cycles(6);
    end
    // Last value powers the converter at half rate, so the tick alternates
    tick_seen = conv_tick_q;
    cycles(1);
    check(conv_tick_q, !tick_seen);
    $display("test control done");
  endtask

  task automatic t_result;
    wr(8'h08, 8'h02);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_data <= 8'hA5;
    @(posedge clk);
    conv_valid <= 1'b0;
    rd(8'h10);
    check(rv, 8'hA5);
    check(conv_tick_q, 1'b1);
    wr(8'h10, 8'hFF);
    rd(8'h10);
    check(rv, 8'hA5);
    rd(8'h14);
    check(rv & 8'h02, 8'h02);
    wr(8'h1C, 8'h02);
    cycles(2);
    check(irq_q, 1'b1);
    wr(8'h1C, 8'h00);
    cycles(2);
    check(irq_q, 1'b0);
    wr(8'h1C, 8'h02);
    wr(8'h18, 8'h02);
    cycles(2);
    check(irq_q, 1'b0);
    rd(8'h18);
    check(rv, 8'h00);
    rd(8'h04);
    check(rv, 8'h00);
    $display("test result done");
  endtask

  task automatic t_lvd;
    timer_one_irq <= 1'b1;
    cycles(3);
    check(irq_five_q, 1'b1);
    wr(8'h0C, 8'h01);
    // The flag is trusted only once the settle time has run out
    cycles(12);
    check(irq_five_q, 1'b0);
    rd(8'h0C);
    check(rv, 8'hF9);
    lvd_trip_async <= 1'b1;
    cycles(6);
    lvd_trip_async <= 1'b0;
    rd(8'h0C);
    check(rv, 8'hFB);
    check(irq_five_q, 1'b1);
    rd(8'h14);
    check(rv & 8'h05, 8'h05);
    pad_unregulated_async <= 1'b1;
    wr(8'h0C, 8'hFD);
    cycles(4);
    rd(8'h0C);
    check(rv, 8'hFF);
    // Detection is switched off as software would before stop mode
    wr(8'h0C, 8'h06);
    cycles(2);
    rd(8'h0C);
    check(rv, 8'hFC);
    timer_one_irq <= 1'b0;
    cycles(3);
    check(irq_five_q, 1'b0);
    $display("test detector done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    bus_req = '0;
    lvd_trip_async = 1'b0;
    pad_unregulated_async = 1'b0;
    timer_one_irq = 1'b0;
    conv_valid = 1'b0;
    conv_data = 8'h00;
    cycles(8);
    sys_rst <= 1'b0;
    t_reset;
    t_ctrl;
    t_result;
    t_lvd;
    report_and_stop;
  end

  // All tests need well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
